// ==== hw/epd_link_consts.svh ====
`ifndef EPD_LINK_CONSTS_SVH
`define EPD_LINK_CONSTS_SVH

// System clock period
`define EPD_CLK_NS 40
// Least time to whole clock cycles, rounded up
`define EPD_CYC(ns) (((ns) + `EPD_CLK_NS - 1) / `EPD_CLK_NS)

// Link timing, slowest (read mode) figures used for every frame
`define EPD_T_SCL_HALF_NS 200
`define EPD_T_CSSU_NS 100
`define EPD_T_CSHLD_NS 65
`define EPD_T_CSHIGH_NS 250
`define EPD_HALF_CYC `EPD_CYC(`EPD_T_SCL_HALF_NS)
`define EPD_SETUP_CYC `EPD_CYC(`EPD_T_CSSU_NS)
`define EPD_HOLD_CYC `EPD_CYC(`EPD_T_CSHLD_NS)
`define EPD_GAP_CYC `EPD_CYC(`EPD_T_CSHIGH_NS)

// Frame shapes
`define EPD_LAST_4W 4'h7
`define EPD_LAST_3W 4'h8
`define EPD_BITS_4W 4'h8
`define EPD_BITS_3W 4'h9
`define EPD_BITS_3W_RD 4'hA

// Strap capture point after reset release
`define EPD_STRAP_AT 2'h2

`endif

// ==== hw/epd_link_pkg.sv ====
package epd_link_pkg;

  // {is_data, byte}
  typedef logic [8:0] link_word_t;

  typedef enum logic [2:0] {
    H_IDLE,
    H_SETUP,
    H_CLK,
    H_HOLD,
    H_GAP
  } host_state_e;

endpackage

// ==== hw/epd_link_if.sv ====
`timescale 1ns/100ps

interface epd_link_if;
  logic sclk;
  logic cs_n;
  logic dc;
  logic hw_reset_n;
  logic bus_mode_select;
  logic busy;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic sda;

  // Board pull-up keeps the line high when neither end drives
  assign sda = !dev_sda_oe_n ? dev_sda_o :
               (!host_sda_oe_n ? host_sda_o : 1'h1);

  modport device (
    input sclk, cs_n, dc, hw_reset_n, bus_mode_select, sda,
    output busy, dev_sda_o, dev_sda_oe_n
  );

  modport host (
    output sclk, cs_n, dc, hw_reset_n, bus_mode_select,
    output host_sda_o, host_sda_oe_n,
    input sda, busy
  );
endinterface

// ==== hw/word_buf.sv ====
`timescale 1ns/100ps

module word_buf
  import epd_link_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire link_word_t in_word,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output link_word_t out_word
);
  link_word_t mem_r [2];
  link_word_t mem_nxt [2];
  logic wp_r;
  logic wp_nxt;
  logic rp_r;
  logic rp_nxt;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic push;
  logic pop;

  assign in_ready = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_word = mem_r[rp_r];

  always_comb
  begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    mem_nxt = mem_r;
    if (push)
      mem_nxt[wp_r] = in_word;
    wp_nxt = wp_r ^ push;
    rp_nxt = rp_r ^ pop;
    cnt_nxt = cnt_r + {1'h0, push} - {1'h0, pop};
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mem_r[0] <= 9'h000;
      mem_r[1] <= 9'h000;
      wp_r <= 1'h0;
      rp_r <= 1'h0;
      cnt_r <= 2'h0;
    end
    else
    begin
      mem_r <= mem_nxt;
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule

// ==== hw/epd_dev_port.sv ====
`timescale 1ns/100ps
`include "epd_link_consts.svh"

module epd_dev_port
  import epd_link_pkg::*;
(
  // Link pins
  epd_link_if.device link,
  // System clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Received bytes
  output logic rx_cmd_valid,
  output logic rx_dat_valid,
  input wire logic rx_ready,
  output logic [7:0] rx_byte,
  // Read replies
  input wire logic [7:0] read_code,
  input wire logic [7:0] reply_byte,
  output logic reply_next,
  // Core status
  input wire logic core_busy,
  output logic core_reset,
  output logic mode_3wire
);
  logic dev_rst;
  logic link_rst;

  assign dev_rst = sys_rst | ~link.hw_reset_n;
  // chip select high holds link logic cleared, except the toggles and word
  assign link_rst = dev_rst | link.cs_n;

  // ---- System side state
  logic strap_s1_r, strap_s1_nxt;
  logic strap_s2_r, strap_s2_nxt;
  logic [1:0] rel_cnt_r, rel_cnt_nxt;
  logic mode_r, mode_nxt;
  logic busy_r, busy_nxt;
  logic core_rst_r, core_rst_nxt;
  logic rx_s1_r, rx_s1_nxt;
  logic rx_s2_r, rx_s2_nxt;
  logic rx_s3_r, rx_s3_nxt;
  logic tx_s1_r, tx_s1_nxt;
  logic tx_s2_r, tx_s2_nxt;
  logic tx_s3_r, tx_s3_nxt;
  logic next_r, next_nxt;
  logic pend_r, pend_nxt;
  link_word_t pend_word_r, pend_word_nxt;
  logic buf_ready;
  logic buf_valid;
  link_word_t buf_word;

  // ---- Link receive state (rising sclk)
  logic [3:0] bit_cnt_r, bit_cnt_nxt;
  logic [8:0] sh_r, sh_nxt;
  logic rd_arm_r, rd_arm_nxt;
  logic rd_go_r, rd_go_nxt;
  logic rx_tog_r, rx_tog_nxt;
  link_word_t word_r, word_nxt;
  logic is_dat;
  logic [3:0] last_bit;

  // ---- Link transmit state (falling sclk)
  logic tx_on_r, tx_on_nxt;
  logic [7:0] tx_sh_r, tx_sh_nxt;
  logic [2:0] tx_cnt_r, tx_cnt_nxt;
  logic tx_tog_r, tx_tog_nxt;

  assign mode_3wire = mode_r;
  assign link.busy = busy_r;
  assign core_reset = core_rst_r;
  assign reply_next = next_r;
  // pin driven from transmit flops only in read phase
  assign link.dev_sda_o = tx_sh_r[7];
  assign link.dev_sda_oe_n = ~tx_on_r;
  assign rx_cmd_valid = buf_valid & ~buf_word[8];
  assign rx_dat_valid = buf_valid & buf_word[8];
  assign rx_byte = buf_word[7:0];

  always_comb
  begin
    strap_s1_nxt = link.bus_mode_select;
    strap_s2_nxt = strap_s1_r;
    rel_cnt_nxt = rel_cnt_r;
    mode_nxt = mode_r;
    // strap caught once after reset release
    if (rel_cnt_r != 2'h3)
      rel_cnt_nxt = rel_cnt_r + 2'h1;
    if (rel_cnt_r == `EPD_STRAP_AT)
      mode_nxt = strap_s2_r;
    busy_nxt = core_busy;
    core_rst_nxt = 1'h0;
    rx_s1_nxt = rx_tog_r;
    rx_s2_nxt = rx_s1_r;
    rx_s3_nxt = rx_s2_r;
    tx_s1_nxt = tx_tog_r;
    tx_s2_nxt = tx_s1_r;
    tx_s3_nxt = tx_s2_r;
    next_nxt = tx_s2_r ^ tx_s3_r;
    pend_nxt = pend_r && !buf_ready;
    pend_word_nxt = pend_word_r;
    // Word is stable: the link rewrites it no sooner than 8 sclk later
    if (rx_s2_r ^ rx_s3_r)
    begin
      pend_nxt = 1'h1;
      pend_word_nxt = word_r;
    end
  end

  always_ff @(posedge clk_sys or posedge dev_rst)
  begin
    if (dev_rst)
    begin
      strap_s1_r <= 1'h0;
      strap_s2_r <= 1'h0;
      rel_cnt_r <= 2'h0;
      mode_r <= 1'h0;
      busy_r <= 1'h0;
      core_rst_r <= 1'h1;
      rx_s1_r <= 1'h0;
      rx_s2_r <= 1'h0;
      rx_s3_r <= 1'h0;
      tx_s1_r <= 1'h0;
      tx_s2_r <= 1'h0;
      tx_s3_r <= 1'h0;
      next_r <= 1'h0;
      pend_r <= 1'h0;
      pend_word_r <= 9'h000;
    end
    else
    begin
      strap_s1_r <= strap_s1_nxt;
      strap_s2_r <= strap_s2_nxt;
      rel_cnt_r <= rel_cnt_nxt;
      mode_r <= mode_nxt;
      busy_r <= busy_nxt;
      core_rst_r <= core_rst_nxt;
      rx_s1_r <= rx_s1_nxt;
      rx_s2_r <= rx_s2_nxt;
      rx_s3_r <= rx_s3_nxt;
      tx_s1_r <= tx_s1_nxt;
      tx_s2_r <= tx_s2_nxt;
      tx_s3_r <= tx_s3_nxt;
      next_r <= next_nxt;
      pend_r <= pend_nxt;
      pend_word_r <= pend_word_nxt;
    end
  end

  word_buf u_buf (
    .clk_sys(clk_sys),
    .sys_rst(dev_rst),
    .in_valid(pend_r),
    .in_ready(buf_ready),
    .in_word(pend_word_r),
    .out_valid(buf_valid),
    .out_ready(rx_ready),
    .out_word(buf_word)
  );

  assign last_bit = mode_r ? `EPD_LAST_3W : `EPD_LAST_4W;

  always_comb
  begin
    bit_cnt_nxt = bit_cnt_r;
    // MSB first into the shift register
    sh_nxt = {sh_r[7:0], link.sda};
    rd_arm_nxt = rd_arm_r;
    rd_go_nxt = rd_go_r;
    rx_tog_nxt = rx_tog_r;
    word_nxt = word_r;
    // dc pin in 4-wire, leading bit in 3-wire
    is_dat = mode_r ? sh_nxt[8] : link.dc;
    if (rd_arm_r)
    begin
      // a 1 here turns the link round, a 0 starts a byte
      rd_arm_nxt = 1'h0;
      rd_go_nxt = link.sda;
      if (!link.sda)
        bit_cnt_nxt = 4'h1;
    end
    else if (!rd_go_r)
    begin
      bit_cnt_nxt = bit_cnt_r + 4'h1;
      if (bit_cnt_r == last_bit)
      begin
        bit_cnt_nxt = 4'h0;
        rx_tog_nxt = ~rx_tog_r;
        word_nxt = {is_dat, sh_nxt[7:0]};
        if (!is_dat && sh_nxt[7:0] == read_code)
        begin
          rd_arm_nxt = mode_r;
          rd_go_nxt = ~mode_r;
        end
      end
    end
  end

  // counter and partial byte cleared by chip select
  always_ff @(posedge link.sclk or posedge link_rst)
  begin
    if (link_rst)
    begin
      bit_cnt_r <= 4'h0;
      sh_r <= 9'h000;
      rd_arm_r <= 1'h0;
      rd_go_r <= 1'h0;
    end
    else
    begin
      bit_cnt_r <= bit_cnt_nxt;
      sh_r <= sh_nxt;
      rd_arm_r <= rd_arm_nxt;
      rd_go_r <= rd_go_nxt;
    end
  end

  // Toggles and the word outlive the frame for the system side
  always_ff @(posedge link.sclk or posedge dev_rst)
  begin
    if (dev_rst)
    begin
      rx_tog_r <= 1'h0;
      word_r <= 9'h000;
    end
    else
    begin
      rx_tog_r <= rx_tog_nxt;
      word_r <= word_nxt;
    end
  end

  always_comb
  begin
    tx_on_nxt = tx_on_r;
    tx_sh_nxt = tx_sh_r;
    tx_cnt_nxt = tx_cnt_r;
    tx_tog_nxt = tx_tog_r;
    // shift on falling edges, reload each byte
    if (rd_go_r)
    begin
      tx_on_nxt = 1'h1;
      if (!tx_on_r || tx_cnt_r == 3'h0)
      begin
        tx_sh_nxt = reply_byte;
        tx_cnt_nxt = 3'h7;
        tx_tog_nxt = ~tx_tog_r;
      end
      else
      begin
        tx_sh_nxt = {tx_sh_r[6:0], 1'h0};
        tx_cnt_nxt = tx_cnt_r - 3'h1;
      end
    end
  end

  // output enable dropped as chip select rises
  always_ff @(negedge link.sclk or posedge link_rst)
  begin
    if (link_rst)
    begin
      tx_on_r <= 1'h0;
      tx_sh_r <= 8'h00;
      tx_cnt_r <= 3'h0;
    end
    else
    begin
      tx_on_r <= tx_on_nxt;
      tx_sh_r <= tx_sh_nxt;
      tx_cnt_r <= tx_cnt_nxt;
    end
  end

  always_ff @(negedge link.sclk or posedge dev_rst)
  begin
    if (dev_rst)
      tx_tog_r <= 1'h0;
    else
      tx_tog_r <= tx_tog_nxt;
  end
endmodule

// ==== hw/epd_host_port.sv ====
`timescale 1ns/100ps
`include "epd_link_consts.svh"

module epd_host_port
  import epd_link_pkg::*;
(
  // Link pins
  epd_link_if.host link,
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Requests
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_is_data,
  input wire logic [7:0] req_byte,
  input wire logic [3:0] req_rd_len,
  // Read answers
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [7:0] rd_byte,
  // Board control
  input wire logic mode_3wire,
  input wire logic dev_reset
);
  host_state_e st_r, st_nxt;
  logic [3:0] tmr_r, tmr_nxt;
  logic sclk_r, sclk_nxt;
  logic cs_n_r, cs_n_nxt;
  logic dc_r, dc_nxt;
  logic sda_r, sda_nxt;
  logic oe_n_r, oe_n_nxt;
  logic [3:0] out_left_r, out_left_nxt;
  logic [6:0] in_left_r, in_left_nxt;
  logic [9:0] tx_sh_r, tx_sh_nxt;
  logic [7:0] rx_sh_r, rx_sh_nxt;
  logic rd_valid_r, rd_valid_nxt;
  logic [7:0] rd_byte_r, rd_byte_nxt;
  logic mode_r, mode_nxt;
  logic rst_n_r, rst_n_nxt;
  logic busy_s1_r, busy_s2_r;
  logic sda_s1_r, sda_s2_r;
  logic is_rd;

  assign link.sclk = sclk_r;
  assign link.cs_n = cs_n_r;
  assign link.dc = dc_r;
  assign link.host_sda_o = sda_r;
  assign link.host_sda_oe_n = oe_n_r;
  assign link.bus_mode_select = mode_r;
  assign link.hw_reset_n = rst_n_r;
  assign rd_valid = rd_valid_r;
  assign rd_byte = rd_byte_r;
  // no new frame while the device is busy
  assign req_ready = (st_r == H_IDLE) && !busy_s2_r && rst_n_r;
  assign is_rd = (req_rd_len != 4'h0);

  always_comb
  begin
    st_nxt = st_r;
    tmr_nxt = tmr_r;
    sclk_nxt = sclk_r;
    cs_n_nxt = cs_n_r;
    dc_nxt = dc_r;
    sda_nxt = sda_r;
    oe_n_nxt = oe_n_r;
    out_left_nxt = out_left_r;
    in_left_nxt = in_left_r;
    tx_sh_nxt = tx_sh_r;
    rx_sh_nxt = rx_sh_r;
    rd_valid_nxt = rd_valid_r && !rd_ready;
    rd_byte_nxt = rd_byte_r;
    mode_nxt = mode_3wire;
    rst_n_nxt = ~dev_reset;
    if (tmr_r != 4'h0)
      tmr_nxt = tmr_r - 4'h1;
    case (st_r)
      H_IDLE:
        if (req_valid && req_ready)
        begin
          if (!mode_r)
          begin
            tx_sh_nxt = {req_byte, 2'h0};
            out_left_nxt = `EPD_BITS_4W;
          end
          else if (is_rd)
          begin
            // command framed by 0 and 1 bits
            tx_sh_nxt = {1'h0, req_byte, 1'h1};
            out_left_nxt = `EPD_BITS_3W_RD;
          end
          else
          begin
            tx_sh_nxt = {req_is_data, req_byte, 1'h0};
            out_left_nxt = `EPD_BITS_3W;
          end
          // dc tied low in 3-wire, steady per byte
          dc_nxt = !mode_r && !is_rd && req_is_data;
          in_left_nxt = {req_rd_len, 3'h0};
          sda_nxt = tx_sh_nxt[9];
          oe_n_nxt = 1'h0;
          cs_n_nxt = 1'h0;
          tmr_nxt = 4'(`EPD_SETUP_CYC - 1);
          st_nxt = H_SETUP;
        end
      H_SETUP:
        if (tmr_r == 4'h0)
        begin
          tmr_nxt = 4'(`EPD_HALF_CYC - 1);
          st_nxt = H_CLK;
        end
      H_CLK:
        if (tmr_r == 4'h0)
        begin
          if (!sclk_r)
          begin
            // Clock is held low while an answer waits
            if (!(rd_valid_r && !rd_ready))
            begin
              sclk_nxt = 1'h1;
              tmr_nxt = 4'(`EPD_HALF_CYC - 1);
              if (out_left_r == 4'h0)
              begin
                rx_sh_nxt = {rx_sh_r[6:0], sda_s2_r};
                in_left_nxt = in_left_r - 7'h01;
                if (in_left_r[2:0] == 3'h1)
                begin
                  rd_valid_nxt = 1'h1;
                  rd_byte_nxt = rx_sh_nxt;
                end
              end
            end
          end
          else
          begin
            sclk_nxt = 1'h0;
            tmr_nxt = 4'(`EPD_HALF_CYC - 1);
            if (out_left_r <= 4'h1 && in_left_r == 7'h00)
            begin
              out_left_nxt = 4'h0;
              tmr_nxt = 4'(`EPD_HOLD_CYC - 1);
              st_nxt = H_HOLD;
            end
            else if (out_left_r == 4'h1)
            begin
              // turn round after the command's last fall
              out_left_nxt = 4'h0;
              oe_n_nxt = 1'h1;
              dc_nxt = !mode_r;
            end
            else if (out_left_r != 4'h0)
            begin
              out_left_nxt = out_left_r - 4'h1;
              tx_sh_nxt = {tx_sh_r[8:0], 1'h0};
              sda_nxt = tx_sh_nxt[9];
            end
          end
        end
      H_HOLD:
        if (tmr_r == 4'h0)
        begin
          cs_n_nxt = 1'h1;
          oe_n_nxt = 1'h1;
          dc_nxt = 1'h0;
          tmr_nxt = 4'(`EPD_GAP_CYC - 1);
          st_nxt = H_GAP;
        end
      H_GAP:
        if (tmr_r == 4'h0)
          st_nxt = H_IDLE;
      default:
        st_nxt = H_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_r <= H_IDLE;
      tmr_r <= 4'h0;
      sclk_r <= 1'h0;
      cs_n_r <= 1'h1;
      dc_r <= 1'h0;
      sda_r <= 1'h0;
      oe_n_r <= 1'h1;
      out_left_r <= 4'h0;
      in_left_r <= 7'h00;
      tx_sh_r <= 10'h000;
      rx_sh_r <= 8'h00;
      rd_valid_r <= 1'h0;
      rd_byte_r <= 8'h00;
      mode_r <= 1'h0;
      rst_n_r <= 1'h0;
      busy_s1_r <= 1'h0;
      busy_s2_r <= 1'h0;
      sda_s1_r <= 1'h0;
      sda_s2_r <= 1'h0;
    end
    else
    begin
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
      sclk_r <= sclk_nxt;
      cs_n_r <= cs_n_nxt;
      dc_r <= dc_nxt;
      sda_r <= sda_nxt;
      oe_n_r <= oe_n_nxt;
      out_left_r <= out_left_nxt;
      in_left_r <= in_left_nxt;
      tx_sh_r <= tx_sh_nxt;
      rx_sh_r <= rx_sh_nxt;
      rd_valid_r <= rd_valid_nxt;
      rd_byte_r <= rd_byte_nxt;
      mode_r <= mode_nxt;
      rst_n_r <= rst_n_nxt;
      busy_s1_r <= link.busy;
      busy_s2_r <= busy_s1_r;
      sda_s1_r <= link.sda;
      sda_s2_r <= sda_s1_r;
    end
  end
endmodule

// ==== test/epd_link_properties.sv ====
`timescale 1ns/100ps

module epd_link_properties (
  // System clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Link wires
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic dc,
  input wire logic hw_reset_n,
  input wire logic bus_mode_select,
  input wire logic busy,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  sda_release_a: assert property (!dev_sda_oe_n |-> !cs_n)
    else $error("device drives data line outside a selected frame");
  sda_contention_a: assert property (!(!dev_sda_oe_n && !host_sda_oe_n))
    else $error("both ends drive the data line");
  clock_idle_a: assert property (cs_n |-> !sclk)
    else $error("link clock moves while deselected");
  dc_steady_a: assert property (!cs_n && sclk && !bus_mode_select |->
    $stable(dc))
    else $error("data/command level changed with clock high");
  dc_tied_a: assert property (bus_mode_select |-> !dc)
    else $error("data/command pin not low in 3-wire mode");
  busy_block_a: assert property ($fell(cs_n) |-> !$past(busy, 3))
    else $error("frame started while busy was high");
  reset_quiet_a: assert property (!hw_reset_n |-> !busy)
    else $error("busy high while device held in reset");
  read_edge_a: assert property (!dev_sda_oe_n && !$past(dev_sda_oe_n)
    && !$fell(sclk) |-> $stable(dev_sda_o))
    else $error("read data changed away from a falling clock");
  dc_raise_a: assert property ($rose(dc) |-> !sclk)
    else $error("data/command raised while clock high");
endmodule

// ==== test/epd_serial_host_port_tb.sv ====
`timescale 1ns/100ps

module epd_serial_host_port_tb;
  import epd_link_pkg::*;
  localparam logic [7:0] READ_CODE = 8'h2F;
  localparam int LIMIT = 60000;
  logic clk_sys, sys_rst, req_valid, req_ready, req_is_data;
  logic rd_valid, rd_ready, mode_sel, dev_reset, rx_cmd_valid;
  logic rx_dat_valid, rx_ready, reply_next, core_busy, core_reset;
  logic mode_3wire;
  logic [7:0] req_byte, rd_byte, rx_byte, reply_byte;
  logic [3:0] req_rd_len;
  logic [7:0] rd_base = 8'h00;
  logic [7:0] rd_cnt = 8'h00;
  bit hold_rx = 0;
  int seed = 71;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  link_word_t rx_q[$];
  logic [7:0] rd_q[$];

  epd_link_if u_epd_link_if ();

  epd_host_port u_epd_host_port (
    .link(u_epd_link_if.host), .clk_sys(clk_sys), .sys_rst(sys_rst),
    .req_valid(req_valid), .req_ready(req_ready),
    .req_is_data(req_is_data), .req_byte(req_byte),
    .req_rd_len(req_rd_len), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .rd_byte(rd_byte), .mode_3wire(mode_sel), .dev_reset(dev_reset)
  );

  epd_dev_port u_epd_dev_port (
    .link(u_epd_link_if.device), .clk_sys(clk_sys), .sys_rst(sys_rst),
    .rx_cmd_valid(rx_cmd_valid), .rx_dat_valid(rx_dat_valid),
    .rx_ready(rx_ready), .rx_byte(rx_byte), .read_code(READ_CODE),
    .reply_byte(reply_byte), .reply_next(reply_next),
    .core_busy(core_busy), .core_reset(core_reset),
    .mode_3wire(mode_3wire)
  );

  epd_link_properties u_epd_link_properties (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .sclk(u_epd_link_if.sclk),
    .cs_n(u_epd_link_if.cs_n), .dc(u_epd_link_if.dc),
    .hw_reset_n(u_epd_link_if.hw_reset_n),
    .bus_mode_select(u_epd_link_if.bus_mode_select),
    .busy(u_epd_link_if.busy),
    .host_sda_oe_n(u_epd_link_if.host_sda_oe_n),
    .dev_sda_o(u_epd_link_if.dev_sda_o),
    .dev_sda_oe_n(u_epd_link_if.dev_sda_oe_n)
  );

  // Reply stream differs per byte so a skipped or repeated load shows
  assign reply_byte = rd_base + 8'h11 * rd_cnt;

  initial
  begin
    clk_sys = 0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic chk_rx(input link_word_t got, input link_word_t exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %0t rx word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %0t read byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_st(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %0t status %b expected %b", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    if (miscompares == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      miscompares++;
      end_sim;
    end
    if (reply_next === 1'b1)
      rd_cnt <= rd_cnt + 8'h01;
    if ((rx_cmd_valid || rx_dat_valid) === 1'b1 && rx_ready === 1'b1)
      chk_rx({rx_dat_valid, rx_byte}, rx_q.size() ? rx_q.pop_front() : 'x);
    if (rd_valid === 1'b1 && rd_ready === 1'b1)
      chk_rd(rd_byte, rd_q.size() ? rd_q.pop_front() : 'x);
  end

  // Receiver stalls at random, and for a long stretch on request
  always @(negedge clk_sys)
  begin
    rx_ready <= !hold_rx && ($random(seed) % 8 != 0);
    rd_ready <= ($random(seed) % 4 != 0);
  end

  task automatic send(input logic d, input logic [7:0] b,
                      input logic [3:0] len);
    @(negedge clk_sys);
    req_valid = 1'b1;
    req_is_data = d;
    req_byte = b;
    req_rd_len = len;
    do
      @(posedge clk_sys);
    while (req_ready !== 1'b1 && cycles < LIMIT);
    // Reply stream restarts only once the previous frame has fully ended
    if (len != 4'h0)
    begin
      rd_base = $random(seed);
      rd_cnt = 8'h00;
    end
    rx_q.push_back({d, b});
    for (int k = 0; k < len; k++)
      rd_q.push_back(rd_base + 8'h11 * 8'(k));
    @(negedge clk_sys);
    req_valid = 1'b0;
  endtask

  task automatic drain;
    while ((req_ready !== 1'b1 || rx_q.size() || rd_q.size())
           && cycles < LIMIT)
      @(negedge clk_sys);
  endtask

  task automatic set_mode(input logic m);
    drain;
    mode_sel = m;
    dev_reset = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk_st(core_reset, 1'b1);
    dev_reset = 1'b0;
    repeat (12) @(negedge clk_sys);
    chk_st(mode_3wire, m);
    chk_st(core_reset, 1'b0);
  endtask

  initial
  begin
    logic [7:0] b;
    logic d;
    sys_rst = 1'b1;
    req_valid = 1'b0;
    req_is_data = 1'b0;
    req_byte = 8'h00;
    req_rd_len = 4'h0;
    mode_sel = 1'b0;
    dev_reset = 1'b0;
    core_busy = 1'b0;
    rx_ready = 1'b0;
    rd_ready = 1'b0;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    sys_rst = 1'b0;
    for (int m = 0; m < 2; m++)
    begin
      set_mode(m[0]);
      for (int i = 0; i < 10; i++)
      begin
        b = $random(seed);
        d = $random(seed);
        if (!d && b == READ_CODE)
          b = b ^ 8'h01;
        hold_rx = (i == 3 || i == 4);
        send(d, b, 4'h0);
      end
      // shortest and longest reads, then a write at once
      send(1'b0, READ_CODE, 4'h1);
      send(1'b0, READ_CODE, 4'hF);
      send(1'b1, 8'hFF, 4'h0);
      drain;
      core_busy = 1'b1;
      repeat (6) @(negedge clk_sys);
      chk_st(req_ready, 1'b0);
      fork
        repeat (40) @(negedge clk_sys);
        send(1'b1, 8'h00, 4'h0);
      join_any
      core_busy = 1'b0;
      // Held request must finish before any mode change resets the device
      wait fork;
      @(negedge clk_sys);
    end
    drain;
    end_sim;
  end
endmodule
